// file: src/phy_mgmt_pkg.sv
// package: register map, field positions, reset values and frame constants
package phy_mgmt_pkg;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [4:0] ADDR_BASIC_CONTROL   = 5'h00;
	localparam logic [4:0] ADDR_BASIC_STATUS    = 5'h01;
	localparam logic [4:0] ADDR_IDENTIFIER_HIGH = 5'h02;

	// ----------------------------------------
	// basic control fields
	// ----------------------------------------
	localparam int CTL_SOFT_RESET   = 15;
	localparam int CTL_LOOPBACK     = 14;
	localparam int CTL_SPEED        = 13;
	localparam int CTL_AUTONEG_EN   = 12;
	localparam int CTL_POWER_DOWN   = 11;
	localparam int CTL_ISOLATE      = 10;
	localparam int CTL_RESTART_AN   = 9;
	localparam int CTL_DUPLEX       = 8;
	localparam int CTL_COL_TEST     = 7;
	localparam int CTL_TX_DISABLE   = 0;

	// ----------------------------------------
	// basic status fields
	// ----------------------------------------
	localparam int STS_AN_COMPLETE  = 5;
	localparam int STS_REMOTE_FAULT = 4;
	localparam int STS_LINK         = 2;
	localparam int STS_JABBER       = 1;
	// fixed capability bits: 100tx fd/hd, 10t fd/hd, no preamble, an ability, ext cap
	localparam logic [15:0] STS_FIXED = 16'h7849;

	// arbitrary neutral identifier value
	localparam logic [15:0] IDENTIFIER_HIGH_VALUE = 16'h1234;

	// ----------------------------------------
	// management frame
	// ----------------------------------------
	localparam logic [1:0] FRAME_START = 2'h1;
	localparam logic [1:0] OP_WRITE    = 2'h1;
	localparam logic [1:0] OP_READ     = 2'h2;
	localparam logic [4:0] PHY_ADDR_RESET = 5'h01;

	typedef enum logic [2:0] {
		ST_IDLE, ST_HEAD, ST_TA, ST_READ, ST_WRITE
	} frame_state_t;

endpackage

// file: src/mgmt_access_if.sv
// interface: register access strobes between frame engine and register bank
`timescale 1ns/1ps
interface mgmt_access_if;
	logic        wr_stb;
	logic        rd_stb;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport engine (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
	modport bank   (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// file: src/mdio_frame_engine.sv
// module: clause 22 management frame decoder on sampled mdc/mdio
`timescale 1ns/1ps
module mdio_frame_engine
	import phy_mgmt_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       mdc_in,
	input  wire logic       mdio_in,
	input  wire logic [4:0] phy_addr_in,
	output logic            mdio_out,
	output logic            mdio_oe_out,
	mgmt_access_if.engine   acc
);
	frame_state_t state;
	logic        mdc_prev;
	logic        skip;
	logic [5:0]  cnt;
	logic [13:0] head;
	logic [15:0] shift;
	logic        is_read;

	wire rise = mdc_in & ~mdc_prev;
	wire fall = ~mdc_in & mdc_prev;
	wire [13:0] next_head = {head[12:0], mdio_in};
	wire head_ok = (next_head[13:12] == FRAME_START) &&
		(next_head[11:10] == OP_READ || next_head[11:10] == OP_WRITE) &&
		(next_head[9:5] == phy_addr_in);

	assign acc.addr = head[4:0];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state       <= ST_IDLE;
			mdc_prev    <= 1'b0;
			skip        <= 1'b0;
			cnt         <= 6'h00;
			head        <= 14'h0000;
			shift       <= 16'h0000;
			is_read     <= 1'b0;
			mdio_out    <= 1'b0;
			mdio_oe_out <= 1'b0;
			acc.wr_stb  <= 1'b0;
			acc.rd_stb  <= 1'b0;
			acc.wdata   <= 16'h0000;
		end else begin
			mdc_prev   <= mdc_in;
			acc.wr_stb <= 1'b0;
			acc.rd_stb <= 1'b0;
			case (state)
			ST_IDLE: begin
				// preamble optional; a zero after idle ones starts a frame
				if (rise) begin
					if (!mdio_in) begin
						head  <= 14'h0000;
						cnt   <= 6'h01;
						state <= ST_HEAD;
					end
				end
			end
			ST_HEAD: begin
				if (rise) begin
					head <= next_head;
					cnt  <= cnt + 6'h01;
					if (cnt == 6'h0d) begin
						if (head_ok) begin
							is_read <= (next_head[11:10] == OP_READ);
							skip    <= 1'b0;
							state   <= ST_TA;
							cnt     <= 6'h00;
						end else begin
							// ride out a foreign frame so its data cannot start a new one
							is_read <= 1'b0;
							skip    <= 1'b1;
							state   <= ST_TA;
							cnt     <= 6'h00;
						end
					end
				end
			end
			ST_TA: begin
				if (rise) begin
					cnt <= cnt + 6'h01;
					if (cnt == 6'h01) begin
						cnt        <= 6'h00;
						state      <= is_read ? ST_READ : ST_WRITE;
						shift      <= acc.rdata;
						// clear-on-read follows the snapshot so latched events are returned
						acc.rd_stb <= is_read;
					end
				end
				// second turnaround bit driven zero for reads
				if (fall && is_read && cnt == 6'h01) begin
					mdio_oe_out <= 1'b1;
					mdio_out    <= 1'b0;
				end
			end
			ST_READ: begin
				if (fall) begin
					mdio_out <= shift[15];
					shift    <= {shift[14:0], 1'b0};
					cnt      <= cnt + 6'h01;
					if (cnt == 6'h10) begin
						mdio_oe_out <= 1'b0;
						state       <= ST_IDLE;
					end
				end
			end
			ST_WRITE: begin
				if (rise) begin
					shift <= {shift[14:0], mdio_in};
					cnt   <= cnt + 6'h01;
					if (cnt == 6'h0f) begin
						acc.wdata  <= {shift[14:0], mdio_in};
						acc.wr_stb <= ~skip;
						state      <= ST_IDLE;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	a_read_drives: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		acc.wr_stb |-> !mdio_oe_out) else $error("write strobe while driving mdio");
	c_write: cover property (@(posedge clk_in) acc.wr_stb);
	c_read: cover property (@(posedge clk_in) acc.rd_stb);
endmodule

// file: src/phy_basic_mgmt_registers.sv
// module: basic control, basic status and identifier registers
`timescale 1ns/1ps
// Operation
// - writing one to software reset reloads the control register from straps and pulses the core reset; latched status is kept and the bit clears itself.
// - speed select picks 100 when one, 10 when zero, ignored while auto-negotiation is on.
// - with auto-negotiation on, the negotiated speed and duplex win; enable resets from strap.
// - isolate cuts the device off the mac interface and the transmit pair; resets from strap.
// - restart auto-negotiation pulses a restart and the bit clears itself.
// - duplex bit one means full duplex; it resets to the inverse of the duplex strap.
// - transmitter disable zero keeps the transmitter on, one turns it off.
// - status reports fixed capabilities: no t4, 100 and 10 in full and half duplex.
// - status reports preamble suppression as supported.
// - auto-negotiation complete reads one once negotiation is done, else zero.
// - jabber and remote fault latch high until the status register is read.
// - link status latches low until the status register is read.
// - status reports auto-negotiation ability as one.
// - status reports extended capability as one.
// - identifier register returns a fixed 16-bit identifier value.
// - power down stops the line functions but keeps management access alive.
module phy_basic_mgmt_registers
	import phy_mgmt_pkg::*;
(
	input  wire logic       CLK_IN,
	input  wire logic       RST_B_IN,
	input  wire logic       MDC_IN,
	input  wire logic       MDIO_IN,
	output logic            MDIO_OUT,
	output logic            MDIO_OE_OUT,
	input  wire logic [4:0] PHY_ADDR_IN,
	input  wire logic       SPEED_STRAP_IN,
	input  wire logic       AUTONEG_STRAP_IN,
	input  wire logic       ISO_STRAP_IN,
	input  wire logic       DUPLEX_STRAP_IN,
	input  wire logic       AN_DONE_IN,
	input  wire logic       AN_SPEED_IN,
	input  wire logic       AN_DUPLEX_IN,
	input  wire logic       LINK_UP_IN,
	input  wire logic       JABBER_IN,
	input  wire logic       REMOTE_FAULT_IN,
	output logic            SPEED_100_OUT,
	output logic            FULL_DUPLEX_OUT,
	output logic            ISOLATE_OUT,
	output logic            TX_ENABLE_OUT,
	output logic            AN_RESTART_OUT,
	output logic            LOOPBACK_OUT,
	output logic            COL_TEST_OUT,
	output logic            POWER_DOWN_OUT,
	output logic            CORE_RESET_OUT
);
	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	mgmt_access_if acc ();

	mdio_frame_engine mdio_frame_engine_inst (
		.clk_in      (CLK_IN),
		.rst_b_in    (RST_B_IN),
		.mdc_in      (MDC_IN),
		.mdio_in     (MDIO_IN),
		.phy_addr_in (PHY_ADDR_IN),
		.mdio_out    (MDIO_OUT),
		.mdio_oe_out (MDIO_OE_OUT),
		.acc         (acc.engine)
	);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	logic [15:0] ctl;
	logic        strap_load;
	logic        soft_reset;
	logic        remote_fault;
	logic        jabber;
	logic        link_ok;

	wire wr_ctl    = acc.wr_stb && (acc.addr == ADDR_BASIC_CONTROL);
	wire rd_status = acc.rd_stb && (acc.addr == ADDR_BASIC_STATUS);
	// writable control bits: 15..7 and 0
	wire [15:0] ctl_mask = 16'hff81;
	wire [15:0] strap_ctl = {2'b00, SPEED_STRAP_IN, AUTONEG_STRAP_IN, 1'b0, ISO_STRAP_IN,
		1'b0, ~DUPLEX_STRAP_IN, 8'h00};

	// straps are caught by a clocked load after reset release, and again on soft reset
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctl        <= 16'h0000;
			strap_load <= 1'b1;
			soft_reset <= 1'b0;
		end else begin
			strap_load <= 1'b0;
			soft_reset <= 1'b0;
			if (strap_load || soft_reset) begin
				ctl <= strap_ctl;
			end else if (wr_ctl) begin
				ctl <= acc.wdata & ctl_mask;
				soft_reset <= acc.wdata[CTL_SOFT_RESET];
			end else begin
				// self-clearing bits drop after one cycle
				ctl[CTL_SOFT_RESET] <= 1'b0;
				ctl[CTL_RESTART_AN] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// latched status
	// ----------------------------------------
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			remote_fault <= 1'b0;
			jabber       <= 1'b0;
			link_ok      <= 1'b0;
		end else begin
			// events in the read cycle are kept: set wins for jabber and remote fault, a link drop wins for link
			remote_fault <= REMOTE_FAULT_IN | (remote_fault & ~rd_status);
			jabber       <= JABBER_IN | (jabber & ~rd_status);
			link_ok      <= LINK_UP_IN & (link_ok | rd_status);
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	wire [15:0] status_word = STS_FIXED | {10'h000, AN_DONE_IN, remote_fault, 1'b0,
		link_ok, jabber, 1'b0};

	assign acc.rdata = (acc.addr == ADDR_BASIC_CONTROL)   ? ctl :
	                   (acc.addr == ADDR_BASIC_STATUS)    ? status_word :
	                   (acc.addr == ADDR_IDENTIFIER_HIGH) ? IDENTIFIER_HIGH_VALUE :
	                   16'h0000;

	// ----------------------------------------
	// operating outputs
	// ----------------------------------------
	wire an_on = ctl[CTL_AUTONEG_EN];
	wire next_speed  = an_on ? AN_SPEED_IN  : ctl[CTL_SPEED];
	wire next_duplex = an_on ? AN_DUPLEX_IN : ctl[CTL_DUPLEX];
	wire pd = ctl[CTL_POWER_DOWN];

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SPEED_100_OUT   <= 1'b0;
			FULL_DUPLEX_OUT <= 1'b0;
			ISOLATE_OUT     <= 1'b0;
			TX_ENABLE_OUT   <= 1'b0;
			AN_RESTART_OUT  <= 1'b0;
			LOOPBACK_OUT    <= 1'b0;
			COL_TEST_OUT    <= 1'b0;
			POWER_DOWN_OUT  <= 1'b0;
			CORE_RESET_OUT  <= 1'b1;
		end else begin
			SPEED_100_OUT   <= next_speed;
			FULL_DUPLEX_OUT <= next_duplex;
			ISOLATE_OUT     <= ctl[CTL_ISOLATE];
			TX_ENABLE_OUT   <= ~ctl[CTL_TX_DISABLE] & ~ctl[CTL_ISOLATE] & ~pd;
			AN_RESTART_OUT  <= ctl[CTL_RESTART_AN];
			LOOPBACK_OUT    <= ctl[CTL_LOOPBACK];
			COL_TEST_OUT    <= ctl[CTL_COL_TEST];
			POWER_DOWN_OUT  <= pd;
			CORE_RESET_OUT  <= soft_reset | strap_load;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_reset_selfclear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		ctl[CTL_SOFT_RESET] |=> !ctl[CTL_SOFT_RESET]) else $error("reset bit stuck");
	a_speed_manual: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		!an_on |=> SPEED_100_OUT == $past(ctl[CTL_SPEED])) else $error("bad speed");
	a_speed_auto: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		an_on |=> SPEED_100_OUT == $past(AN_SPEED_IN)) else $error("bad an speed");
	a_isolate_out: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		ctl[CTL_ISOLATE] |=> ISOLATE_OUT && !TX_ENABLE_OUT) else $error("not isolated");
	a_restart_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		ctl[CTL_RESTART_AN] |=> AN_RESTART_OUT && !ctl[CTL_RESTART_AN]) else $error("restart");
	a_duplex_manual: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		!an_on |=> FULL_DUPLEX_OUT == $past(ctl[CTL_DUPLEX])) else $error("bad duplex");
	a_tx_disable: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		ctl[CTL_TX_DISABLE] |=> !TX_ENABLE_OUT) else $error("tx not off");
	a_fixed_caps: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		status_word[15:11] == 5'h0f && status_word[6] && status_word[3] && status_word[0])
		else $error("bad caps");
	a_jabber_hold: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		JABBER_IN ##1 !rd_status |=> jabber) else $error("jabber lost");
	a_link_low: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		!LINK_UP_IN ##1 !rd_status |=> !link_ok) else $error("link not latched low");
	a_powerdown_tx: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
		pd |=> !TX_ENABLE_OUT) else $error("tx on in power down");

	c_soft_reset: cover property (@(posedge CLK_IN) soft_reset);
	c_link_drop: cover property (@(posedge CLK_IN) $fell(link_ok));
	c_status_read: cover property (@(posedge CLK_IN) rd_status && jabber);
endmodule

// file: dv/mdio_master_model.sv
// partner: station management controller sending clause 22 frames
`timescale 1ns/1ps
module mdio_master_model
	import phy_mgmt_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic mdio_line_in,
	output logic      mdc_out,
	output logic      mdio_out,
	output logic      mdio_oe_out
);
	// mdc stands low outside frames, line released
	initial begin
		mdc_out = 1'b0;
		mdio_out = 1'b1;
		mdio_oe_out = 1'b0;
	end
	// one mdc period of nine clocks, data changed while mdc low
	task automatic put_bit(input logic b, input logic drv, output logic got);
		@(negedge clk_in);
		mdio_out = b;
		mdio_oe_out = drv;
		repeat (4) @(negedge clk_in);
		mdc_out = 1'b1;
		got = mdio_line_in;
		repeat (4) @(negedge clk_in);
		mdc_out = 1'b0;
	endtask
	// ---------------------------------------------
	// whole frame, msb first, ta and read data released on reads, all bits driven on writes
	// ---------------------------------------------
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] bits;
		logic        g;
		bits = {FRAME_START, op, pa, ra, 2'h2, wd};
		put_bit(1'b1, 1'b1, g);
		for (int i = 31; i >= 0; i--) begin
			put_bit(bits[i], (op == OP_WRITE) || (i > 17), g);
			if (i < 16) rd[i] = g;
		end
		put_bit(1'b1, 1'b0, g);
	endtask
endmodule

// file: dv/tb_phy_basic_mgmt_registers.sv
// testbench: management frames against the basic register block
`timescale 1ns/1ps
module tb_phy_basic_mgmt_registers import phy_mgmt_pkg::*;;
	logic        clk, rst_b, s_speed, s_an, s_iso, s_dup;
	int          an_pulses, core_pulses, n;
	logic        an_done, an_speed, an_dup, link_up, jabber, rfault;
	logic [4:0]  pa;
	logic [15:0] r, v, w, e;
	int          miscompares, compares;
	wire         mdc, m_dout, m_oe, d_out, d_oe, spd, fdx, iso, txen, anr, lb, colt, pd, core;
	wire         line = d_oe ? d_out : (m_oe ? m_dout : 1'b1);

	phy_basic_mgmt_registers phy_basic_mgmt_registers_inst (
		.CLK_IN(clk), .RST_B_IN(rst_b), .MDC_IN(mdc), .MDIO_IN(line),
		.MDIO_OUT(d_out), .MDIO_OE_OUT(d_oe), .PHY_ADDR_IN(pa),
		.SPEED_STRAP_IN(s_speed), .AUTONEG_STRAP_IN(s_an), .ISO_STRAP_IN(s_iso),
		.DUPLEX_STRAP_IN(s_dup), .AN_DONE_IN(an_done), .AN_SPEED_IN(an_speed),
		.AN_DUPLEX_IN(an_dup), .LINK_UP_IN(link_up), .JABBER_IN(jabber),
		.REMOTE_FAULT_IN(rfault), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fdx),
		.ISOLATE_OUT(iso), .TX_ENABLE_OUT(txen), .AN_RESTART_OUT(anr),
		.LOOPBACK_OUT(lb), .COL_TEST_OUT(colt), .POWER_DOWN_OUT(pd), .CORE_RESET_OUT(core));
	mdio_master_model mdio_master_model_inst (
		.clk_in(clk), .mdio_line_in(line), .mdc_out(mdc), .mdio_out(m_dout), .mdio_oe_out(m_oe));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] ctl_default();
		return {2'h0, s_speed, s_an, 1'b0, s_iso, 1'b0, ~s_dup, 8'h00};
	endfunction
	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		chk_reg({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic chk_pins(input logic [15:0] c);
		chk_pin(spd, c[CTL_AUTONEG_EN] ? an_speed : c[CTL_SPEED]);
		chk_pin(fdx, c[CTL_AUTONEG_EN] ? an_dup : c[CTL_DUPLEX]);
		chk_pin(iso, c[CTL_ISOLATE]);
		chk_pin(txen, ~c[CTL_TX_DISABLE] & ~c[CTL_ISOLATE] & ~c[CTL_POWER_DOWN]);
		chk_pin(lb, c[CTL_LOOPBACK]);
		chk_pin(colt, c[CTL_COL_TEST]);
		chk_pin(pd, c[CTL_POWER_DOWN]);
	endtask
	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		mdio_master_model_inst.frame(OP_READ, pa, ra, 16'h0000, d);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		mdio_master_model_inst.frame(OP_WRITE, pa, ra, d, x);
	endtask
	task automatic end_sim();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (anr === 1'b1) an_pulses <= an_pulses + 1;
		if (core === 1'b1) core_pulses <= core_pulses + 1;
	end
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		r = 16'h001b;
		{rst_b, an_done, an_speed, an_dup, link_up, jabber, rfault} = 7'h04;
		{s_speed, s_an, s_iso, s_dup} = r[3:0];
		pa = r[8:4];
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		rd(ADDR_BASIC_CONTROL, v);
		chk_reg(v, ctl_default());
		rd(ADDR_BASIC_STATUS, v);
		chk_reg(v, STS_FIXED);
		rd(ADDR_BASIC_STATUS, v);
		chk_reg(v, STS_FIXED | 16'h0004);
		an_done = 1'b1;
		{jabber, rfault, link_up} = 3'h6;
		repeat (3) @(negedge clk);
		{jabber, rfault, link_up} = 3'h1;
		rd(ADDR_BASIC_STATUS, v);
		chk_reg(v, STS_FIXED | 16'h0032);
		rd(ADDR_BASIC_STATUS, v);
		chk_reg(v, STS_FIXED | 16'h0024);
		chk_pins(ctl_default());
		$display("test defaults_status done");
		rd(ADDR_IDENTIFIER_HIGH, v);
		chk_reg(v, IDENTIFIER_HIGH_VALUE);
		wr(5'h1f, 16'hffff);
		rd(5'h1f, v);
		chk_reg(v, 16'h0000);
		$display("test ident_unmapped done");
		for (int i = 0; i < 14; i++) begin
			r = lfsr(r);
			w = (i == 0) ? 16'h7dff : (i == 1) ? 16'h0000 : (r & 16'h7dff);
			{an_speed, an_dup} = r[15:14];
			wr(ADDR_BASIC_CONTROL, w);
			e = w & 16'h7d81;
			rd(ADDR_BASIC_CONTROL, v);
			chk_reg(v, e);
			chk_pins(e);
		end
		mdio_master_model_inst.frame(OP_WRITE, pa ^ 5'h01, ADDR_BASIC_CONTROL, 16'h0001, v);
		rd(ADDR_BASIC_CONTROL, v);
		chk_reg(v, e);
		$display("test control_random done");
		n = an_pulses;
		wr(ADDR_BASIC_CONTROL, e | 16'h0200);
		chk_reg(16'(an_pulses - n), 16'h0001);
		rd(ADDR_BASIC_CONTROL, v);
		chk_reg(v, e);
		r = lfsr(r);
		{s_speed, s_an, s_iso, s_dup} = r[3:0];
		n = core_pulses;
		wr(ADDR_BASIC_CONTROL, 16'h8000);
		chk_reg(16'(core_pulses - n), 16'h0001);
		rd(ADDR_BASIC_CONTROL, v);
		chk_reg(v, ctl_default());
		chk_pins(ctl_default());
		$display("test self_clearing done");
		end_sim();
	end
endmodule
